//--- src/dps_pkg.sv
// package: register map, timing and types for the doubler protection supervisor
package dps_pkg;
  localparam int CLK_NS = 20;
  // register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] EVENT_OFF = 8'h04;
  localparam logic [7:0] MASK_OFF = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0c;
  localparam logic [7:0] LEVEL_OFF = 8'h10;
  // control fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_FREQ_LO = 1;
  localparam int CTRL_CONT_BIT = 3;
  localparam int CTRL_OCDIS_BIT = 4;
  localparam logic [1:0] FREQ_RST = 2'h0;
  // threshold fields
  localparam int LVL_BAT_LO = 0;
  localparam int LVL_IIN_LO = 8;
  localparam int LVL_TMP_LO = 16;
  localparam logic [7:0] TEMP_WARN_MIN = 8'h46;
  localparam logic [7:0] TEMP_WARN_MAX = 8'h7d;
  // adc channel codes
  localparam logic [2:0] CH_VBAT = 3'h2;
  localparam logic [2:0] CH_IIN = 3'h3;
  localparam logic [2:0] CH_TJUNC = 3'h6;
  // deglitch times in ns and their cycle counts (least times, round up)
  localparam int DEG_OV_NS = 20000;
  localparam int DEG_UV_NS = 20000;
  localparam int DEG_RATIO_NS = 10000;
  localparam int DEG_PEAK_NS = 5000;
  function automatic logic [15:0] cyc(input int ns);
    cyc = 16'((ns + CLK_NS - 1) / CLK_NS);
  endfunction
  // deglitched comparator slots
  localparam int NDEG = 7;
  localparam int D_VIN_OV = 0;
  localparam int D_VIN_UV = 1;
  localparam int D_BAT_OV = 2;
  localparam int D_BAT_UV = 3;
  localparam int D_RLOW = 4;
  localparam int D_RHIGH = 5;
  localparam int D_PEAK = 6;
  localparam logic [15:0] DEG_LIM [NDEG] = '{cyc(DEG_OV_NS), cyc(DEG_UV_NS),
    cyc(DEG_OV_NS), cyc(DEG_UV_NS), cyc(DEG_RATIO_NS), cyc(DEG_RATIO_NS),
    cyc(DEG_PEAK_NS)};
  // event register, bit 0 is ratio_low_event
  typedef struct packed {
    logic temp_critical_event;
    logic temp_warning_event;
    logic input_overcurrent_event;
    logic battery_warning_event;
    logic battery_under_event;
    logic battery_over_event;
    logic input_under_event;
    logic input_over_event;
    logic adaptor_present_event;
    logic peak_limit_crit_event;
    logic ratio_high_event;
    logic ratio_low_event;
  } dps_evt_type;
  localparam int EVT_W = 12;
  localparam logic [EVT_W-1:0] MASK_RST = 12'hfff;
  typedef enum logic [1:0] {MODE_IDLE, MODE_ACTIVE, MODE_SHUTDOWN}
    dps_mode_type;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- src/dps_supervisor.sv
// doubler protection supervisor with an axi4-lite register slave
// Function
// - outside active mode the doubler blocks current both ways.
// - switching frequency follows the frequency field only.
// - start only with ratio in window, else abort and raise ratio event.
// - after start fault, resume needs ratio in window and event cleared.
// - peak limit past its deglitch disables doubler, raises event.
// - ratio fault past deglitch while running clears enable, raises event.
// - adaptor rise sets status and event; fall clears status and enable.
// - input overvoltage past deglitch clears enable, raises event.
// - input undervoltage past deglitch clears enable, raises event.
// - input lost raises under event and input pull-down; threshold follows adaptor status.
// - battery overvoltage clears enable, raises event; output pull-down.
// - battery undervoltage past deglitch disables doubler, raises event.
// - continuous mode, non-zero level: battery above level warns.
// - input current above level raises event, optionally clears enable too.
// - overcurrent compare only in continuous mode with non-zero level.
// - temperature warning level 70..125, event on each crossing, status readable.
// - critical temperature raises event, goes idle until below critical.
// - top temperature level forces shutdown, held while above critical.
// - each voltage protection has its own event per comparator trip, but input lost shares the input under event.
// - pin falling edge sets enable, rising clears; writes also start or stop.
// - active-low interrupt while any unmasked event remains set.
`timescale 1ns/1ps
module dps_supervisor (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // axi4-lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // analogue comparators
  input wire logic vin_over_cmp,
  input wire logic vin_under_cmp,
  input wire logic vin_adaptor_cmp,
  input wire logic vin_lost_cmp,
  input wire logic bat_over_cmp,
  input wire logic bat_under_cmp,
  input wire logic ratio_low_cmp,
  input wire logic ratio_high_cmp,
  input wire logic peak_limit_cmp,
  input wire logic temp_crit_cmp,
  input wire logic temp_top_cmp,
  // adc results
  input wire logic adc_valid,
  input wire logic [2:0] adc_chan,
  input wire logic [7:0] adc_data,
  // enable pin
  input wire logic enable_pin_n,
  // power stage and system
  output logic reverse_block,
  output logic doubler_run,
  output logic [1:0] switch_freq,
  output logic out_pulldown,
  output logic in_pulldown,
  output logic uv_thresh_sel,
  output logic interrupt_out_n
);
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction
  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, dps_pkg::CTRL_OFF) | hit(a, dps_pkg::EVENT_OFF) |
      hit(a, dps_pkg::MASK_OFF) | hit(a, dps_pkg::STATUS_OFF) |
      hit(a, dps_pkg::LEVEL_OFF);
  endfunction

  // ---------------- bus slave
  logic aw_full_r, w_full_r, bvalid_r, rvalid_r, awready_r, wready_r;
  logic arready_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r, rdata_r;
  logic [1:0] bresp_r, rresp_r;
  wire aw_take = awvalid & awready_r;
  wire w_take = wvalid & wready_r;
  wire aw_have = aw_full_r | aw_take;
  wire w_have = w_full_r | w_take;
  wire [7:0] wr_addr = aw_full_r ? aw_addr_r : awaddr;
  wire [31:0] wr_data = w_full_r ? w_data_r : wdata;
  wire wr_do = aw_have & w_have & ~bvalid_r;
  wire wr_ok = wr_do & mapped(wr_addr) & (wstrb != 4'h0);
  wire wr_ctrl = wr_ok & hit(wr_addr, dps_pkg::CTRL_OFF);
  wire wr_evt = wr_ok & hit(wr_addr, dps_pkg::EVENT_OFF);
  wire wr_mask = wr_ok & hit(wr_addr, dps_pkg::MASK_OFF);
  wire wr_lvl = wr_ok & hit(wr_addr, dps_pkg::LEVEL_OFF);
  wire aw_full_nxt = aw_have & ~wr_do;
  wire w_full_nxt = w_have & ~wr_do;
  wire bvalid_nxt = wr_do | (bvalid_r & ~bready);
  wire ar_take = arvalid & arready_r;
  wire rvalid_nxt = ar_take | (rvalid_r & ~rready);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= dps_pkg::RESP_OKAY;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0;
    end else begin
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      awready_r <= ~aw_full_nxt & ~bvalid_nxt;
      wready_r <= ~w_full_nxt & ~bvalid_nxt;
      bvalid_r <= bvalid_nxt;
      if (aw_take)
        aw_addr_r <= awaddr;
      if (w_take)
        w_data_r <= wdata;
      if (wr_do)
        bresp_r <= wr_ok ? dps_pkg::RESP_OKAY : dps_pkg::RESP_SLVERR;
    end
  end

  // ---------------- registers
  logic en_r, cont_r, ocdis_r;
  logic [1:0] freq_r;
  dps_pkg::dps_evt_type evt_r;
  logic [dps_pkg::EVT_W-1:0] mask_r;
  logic [7:0] bat_lvl_r, iin_lvl_r, tmp_lvl_r;
  dps_pkg::dps_mode_type mode_r;
  logic adp_stat_r, bat_ov_stat_r, twarn_stat_r;
  logic pin_prev_r, adp_prev_r, lost_prev_r, tcrit_prev_r;
  logic [15:0] deg_cnt_r [dps_pkg::NDEG];

  // ---------------- deglitch filters
  logic [dps_pkg::NDEG-1:0] cmp_in, trip;
  assign cmp_in = {peak_limit_cmp, ratio_high_cmp, ratio_low_cmp,
    bat_under_cmp, bat_over_cmp, vin_under_cmp, vin_over_cmp};
  always_comb begin
    for (int i = 0; i < dps_pkg::NDEG; i++)
      trip[i] = cmp_in[i] & (deg_cnt_r[i] == dps_pkg::DEG_LIM[i] - 16'h1);
  end
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < dps_pkg::NDEG; i++) begin
      if (!rst_n || !cmp_in[i])
        deg_cnt_r[i] <= 16'h0;
      else if (deg_cnt_r[i] != dps_pkg::DEG_LIM[i])
        deg_cnt_r[i] <= deg_cnt_r[i] + 16'h1;
    end
  end

  // ---------------- event sources
  wire running = (mode_r == dps_pkg::MODE_ACTIVE);
  wire ratio_bad = ratio_low_cmp | ratio_high_cmp;
  wire start_abort = (mode_r == dps_pkg::MODE_IDLE) & en_r &
    ~temp_crit_cmp & ~temp_top_cmp & adp_stat_r & ratio_bad;
  wire adc_vbat = adc_valid & (adc_chan == dps_pkg::CH_VBAT);
  wire adc_iin = adc_valid & (adc_chan == dps_pkg::CH_IIN);
  wire adc_tmp = adc_valid & (adc_chan == dps_pkg::CH_TJUNC);
  wire bat_warn = adc_vbat & cont_r & (bat_lvl_r != 8'h00) &
    (adc_data > bat_lvl_r);
  wire iin_oc = adc_iin & cont_r & (iin_lvl_r != 8'h00) &
    (adc_data > iin_lvl_r);
  wire [7:0] tmp_eff = (tmp_lvl_r < dps_pkg::TEMP_WARN_MIN) ?
    dps_pkg::TEMP_WARN_MIN : (tmp_lvl_r > dps_pkg::TEMP_WARN_MAX) ?
    dps_pkg::TEMP_WARN_MAX : tmp_lvl_r;
  wire twarn_now = adc_data > tmp_eff;
  wire twarn_chg = adc_tmp & (twarn_now != twarn_stat_r);
  wire adp_rise = vin_adaptor_cmp & ~adp_prev_r;
  wire adp_fall = ~vin_adaptor_cmp & adp_prev_r;

  dps_pkg::dps_evt_type evt_set;
  always_comb begin
    evt_set = '0;
    evt_set.ratio_low_event = (trip[dps_pkg::D_RLOW] & running) |
      (start_abort & ratio_low_cmp);
    evt_set.ratio_high_event = (trip[dps_pkg::D_RHIGH] & running) |
      (start_abort & ratio_high_cmp);
    evt_set.peak_limit_crit_event = trip[dps_pkg::D_PEAK];
    evt_set.adaptor_present_event = adp_rise;
    evt_set.input_over_event = trip[dps_pkg::D_VIN_OV];
    evt_set.input_under_event = trip[dps_pkg::D_VIN_UV] |
      (vin_lost_cmp & ~lost_prev_r);
    evt_set.battery_over_event = trip[dps_pkg::D_BAT_OV];
    evt_set.battery_under_event = trip[dps_pkg::D_BAT_UV];
    evt_set.battery_warning_event = bat_warn;
    evt_set.input_overcurrent_event = iin_oc;
    evt_set.temp_warning_event = twarn_chg;
    evt_set.temp_critical_event = temp_crit_cmp & ~tcrit_prev_r;
  end
  // set wins over a write-one-to-clear in the same cycle
  wire [dps_pkg::EVT_W-1:0] evt_clr = wr_evt ?
    wr_data[dps_pkg::EVT_W-1:0] : '0;
  wire [dps_pkg::EVT_W-1:0] evt_nxt = (evt_r & ~evt_clr) | evt_set;

  // ---------------- doubler enable bit
  wire block_evt = evt_r.ratio_low_event | evt_r.ratio_high_event |
    evt_r.peak_limit_crit_event | evt_r.input_over_event |
    evt_r.input_under_event | evt_r.battery_over_event |
    evt_r.battery_under_event;
  wire pin_fall = ~enable_pin_n & pin_prev_r;
  wire pin_rise = enable_pin_n & ~pin_prev_r;
  wire en_set = (pin_fall | (wr_ctrl & wr_data[dps_pkg::CTRL_EN_BIT])) &
    ~block_evt;
  wire fault_clr = trip[dps_pkg::D_VIN_OV] | trip[dps_pkg::D_VIN_UV] |
    trip[dps_pkg::D_BAT_OV] | trip[dps_pkg::D_BAT_UV] |
    trip[dps_pkg::D_PEAK] | start_abort | adp_fall | (iin_oc & ocdis_r) |
    (running & (trip[dps_pkg::D_RLOW] | trip[dps_pkg::D_RHIGH]));
  wire en_clr = pin_rise | (wr_ctrl & ~wr_data[dps_pkg::CTRL_EN_BIT]) |
    fault_clr;
  wire en_nxt = en_clr ? 1'b0 : (en_set ? 1'b1 : en_r);
  // mask as it will stand after this edge, so irq tracks the new mask
  wire [dps_pkg::EVT_W-1:0] mask_nxt = wr_mask ?
    wr_data[dps_pkg::EVT_W-1:0] : mask_r;

  // ---------------- operating mode
  dps_pkg::dps_mode_type mode_nxt;
  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      dps_pkg::MODE_IDLE: begin
        if (en_r & adp_stat_r & ~ratio_bad & ~block_evt & ~temp_crit_cmp)
          mode_nxt = dps_pkg::MODE_ACTIVE;
      end
      dps_pkg::MODE_ACTIVE: begin
        if (~en_r | temp_crit_cmp)
          mode_nxt = dps_pkg::MODE_IDLE;
      end
      dps_pkg::MODE_SHUTDOWN: begin
        if (~temp_crit_cmp)
          mode_nxt = dps_pkg::MODE_IDLE;
      end
    endcase
    if (temp_top_cmp)
      mode_nxt = dps_pkg::MODE_SHUTDOWN;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      en_r <= 1'b0;
      cont_r <= 1'b1;
      ocdis_r <= 1'b0;
      freq_r <= dps_pkg::FREQ_RST;
      evt_r <= '0;
      mask_r <= dps_pkg::MASK_RST;
      bat_lvl_r <= 8'h00;
      iin_lvl_r <= 8'h00;
      tmp_lvl_r <= dps_pkg::TEMP_WARN_MAX;
      mode_r <= dps_pkg::MODE_IDLE;
      adp_stat_r <= 1'b0;
      bat_ov_stat_r <= 1'b0;
      twarn_stat_r <= 1'b0;
      pin_prev_r <= 1'b1;
      adp_prev_r <= 1'b0;
      lost_prev_r <= 1'b0;
      tcrit_prev_r <= 1'b0;
    end else begin
      en_r <= en_nxt;
      if (wr_ctrl) begin
        freq_r <= wr_data[dps_pkg::CTRL_FREQ_LO +: 2];
        cont_r <= wr_data[dps_pkg::CTRL_CONT_BIT];
        ocdis_r <= wr_data[dps_pkg::CTRL_OCDIS_BIT];
      end
      evt_r <= evt_nxt;
      if (wr_mask)
        mask_r <= wr_data[dps_pkg::EVT_W-1:0];
      if (wr_lvl) begin
        bat_lvl_r <= wr_data[dps_pkg::LVL_BAT_LO +: 8];
        iin_lvl_r <= wr_data[dps_pkg::LVL_IIN_LO +: 8];
        tmp_lvl_r <= wr_data[dps_pkg::LVL_TMP_LO +: 8];
      end
      mode_r <= mode_nxt;
      adp_stat_r <= adp_rise | (adp_stat_r & ~adp_fall);
      bat_ov_stat_r <= trip[dps_pkg::D_BAT_OV] |
        (bat_ov_stat_r & bat_over_cmp);
      if (twarn_chg)
        twarn_stat_r <= twarn_now;
      pin_prev_r <= enable_pin_n;
      adp_prev_r <= vin_adaptor_cmp;
      lost_prev_r <= vin_lost_cmp;
      tcrit_prev_r <= temp_crit_cmp;
    end
  end

  // ---------------- read path
  wire [31:0] ctrl_word = {27'h0, ocdis_r, cont_r, freq_r, en_r};
  wire [31:0] stat_word = {25'h0, running, mode_r, temp_crit_cmp,
    twarn_stat_r, bat_ov_stat_r, adp_stat_r};
  wire [31:0] lvl_word = {8'h00, tmp_lvl_r, iin_lvl_r, bat_lvl_r};
  wire [31:0] rd_word =
    hit(araddr, dps_pkg::CTRL_OFF) ? ctrl_word :
    hit(araddr, dps_pkg::EVENT_OFF) ? {20'h0, evt_r} :
    hit(araddr, dps_pkg::MASK_OFF) ? {20'h0, mask_r} :
    hit(araddr, dps_pkg::STATUS_OFF) ? stat_word :
    hit(araddr, dps_pkg::LEVEL_OFF) ? lvl_word : 32'h0;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= dps_pkg::RESP_OKAY;
    end else begin
      rvalid_r <= rvalid_nxt;
      arready_r <= ~rvalid_nxt;
      if (ar_take) begin
        rdata_r <= rd_word;
        rresp_r <= mapped(araddr) ? dps_pkg::RESP_OKAY :
          dps_pkg::RESP_SLVERR;
      end
    end
  end

  // ---------------- registered outputs
  logic rb_r, run_r, opd_r, ipd_r, uvs_r, irq_n_r;
  logic [1:0] fout_r;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rb_r <= 1'b1;
      run_r <= 1'b0;
      fout_r <= dps_pkg::FREQ_RST;
      opd_r <= 1'b0;
      ipd_r <= 1'b0;
      uvs_r <= 1'b0;
      irq_n_r <= 1'b1;
    end else begin
      rb_r <= (mode_nxt != dps_pkg::MODE_ACTIVE);
      run_r <= (mode_nxt == dps_pkg::MODE_ACTIVE);
      fout_r <= freq_r;
      opd_r <= bat_ov_stat_r;
      ipd_r <= vin_lost_cmp;
      uvs_r <= adp_stat_r;
      irq_n_r <= ~|(evt_nxt & ~mask_nxt);
    end
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign reverse_block = rb_r;
  assign doubler_run = run_r;
  assign switch_freq = fout_r;
  assign out_pulldown = opd_r;
  assign in_pulldown = ipd_r;
  assign uv_thresh_sel = uvs_r;
  assign interrupt_out_n = irq_n_r;

  // ---------------- assertions
  block_idle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reverse_block == (mode_r != dps_pkg::MODE_ACTIVE))
    else $error("reverse block disagrees with mode");
  freq_follow_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $stable(freq_r) |=> $stable(switch_freq))
    else $error("switching frequency changed on its own");
  start_abort_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    start_abort |=> !en_r && (evt_r.ratio_low_event || evt_r.ratio_high_event))
    else $error("start with bad ratio not aborted");
  peak_trip_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    trip[dps_pkg::D_PEAK] |=> !en_r && evt_r.peak_limit_crit_event)
    else $error("peak limit trip missed");
  pin_edge_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(enable_pin_n) |=> !en_r)
    else $error("enable pin release did not clear enable");
  out_pull_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    bat_ov_stat_r |=> out_pulldown)
    else $error("output pull-down missing during battery overvoltage");
  top_temp_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    temp_top_cmp |=> mode_r == dps_pkg::MODE_SHUTDOWN ##1 reverse_block)
    else $error("top temperature did not shut down");
  evt_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (evt_r.input_over_event && !wr_evt) |=> evt_r.input_over_event)
    else $error("event lost without a clear");
  irq_level_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (|(evt_r & ~mask_r)) |-> !interrupt_out_n)
    else $error("interrupt not asserted for unmasked event");
endmodule

//--- tb/dps_supervisor_test.sv
// self-checking bench for the doubler protection supervisor
`timescale 1ns/1ps
module dps_supervisor_test;
  logic core_clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic adc_valid, enable_pin_n, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr, adc_data;
  logic [31:0] wdata, rdata, rd_v, exp_evt, seed, lvl;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, switch_freq, rd_r;
  logic [2:0] adc_chan;
  logic [10:0] cmp;
  logic reverse_block, doubler_run, out_pulldown, in_pulldown;
  logic uv_thresh_sel, interrupt_out_n;
  int n_errors, checks;
  // comparator slot, hold limit and event bit of each deglitched fault
  int src [7] = '{0, 1, 4, 5, 6, 7, 8};
  int lim [7] = '{1000, 1000, 1000, 1000, 500, 500, 250};
  int eb [7] = '{4, 5, 6, 7, 0, 1, 2};
  logic [7:0] ra [6] = '{dps_pkg::CTRL_OFF, dps_pkg::EVENT_OFF,
    dps_pkg::MASK_OFF, dps_pkg::STATUS_OFF, dps_pkg::LEVEL_OFF, 8'h14};
  logic [31:0] rv [6] = '{32'h8, 32'h0, 32'hfff, 32'h0, 32'h7d0000, 32'h0};

  dps_supervisor u_dut (.core_clk(core_clk), .rst_n(rst_n),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .vin_over_cmp(cmp[0]), .vin_under_cmp(cmp[1]),
    .vin_adaptor_cmp(cmp[2]), .vin_lost_cmp(cmp[3]),
    .bat_over_cmp(cmp[4]), .bat_under_cmp(cmp[5]),
    .ratio_low_cmp(cmp[6]), .ratio_high_cmp(cmp[7]),
    .peak_limit_cmp(cmp[8]), .temp_crit_cmp(cmp[9]),
    .temp_top_cmp(cmp[10]), .adc_valid(adc_valid), .adc_chan(adc_chan),
    .adc_data(adc_data), .enable_pin_n(enable_pin_n),
    .reverse_block(reverse_block), .doubler_run(doubler_run),
    .switch_freq(switch_freq), .out_pulldown(out_pulldown),
    .in_pulldown(in_pulldown), .uv_thresh_sel(uv_thresh_sel),
    .interrupt_out_n(interrupt_out_n));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, exp, input string msg);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic bound(int n);
    if (n >= 100) begin
      n_errors++;
      $display("[FAIL] %0t bus wait ran out", $time);
      tally_and_finish();
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    bound(n);
    rd_r = bresp;
    bready <= 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    bound(n);
    rd_v = rdata;
    rd_r = rresp;
    rready <= 1'b0;
    tick(1);
  endtask

  task automatic ev();
    rd(dps_pkg::EVENT_OFF);
    chk(rd_v, exp_evt, "events");
  endtask

  task automatic clr();
    wr(dps_pkg::EVENT_OFF, 32'hfff);
    exp_evt = 32'h0;
  endtask

  task automatic run();
    wr(dps_pkg::CTRL_OFF, 32'h09);
    tick(4);
  endtask

  task automatic adc(input logic [2:0] ch, input logic [7:0] d);
    adc_valid <= 1'b1;
    adc_chan <= ch;
    adc_data <= d;
    tick(1);
    adc_valid <= 1'b0;
    tick(3);
  endtask

  initial begin
    rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, adc_valid} = '0;
    {awaddr, araddr, adc_data, wdata, wstrb, adc_chan} = '0;
    cmp = '0;
    enable_pin_n = 1'b1;
    exp_evt = 32'h0;
    seed = 32'h14;
    n_errors = 0;
    checks = 0;
    tick(2);
    rst_n <= 1'b1;
    tick(1);
    chk({reverse_block, doubler_run}, 2'b10, "idle blocks");
    for (int i = 0; i < 6; i++) begin
      rd(ra[i]);
      chk(rd_v, rv[i], "reset value");
      chk(rd_r, (i == 5) ? 2'h2 : 2'h0, "read resp");
    end
    wr(8'h14, 32'h1);
    chk(rd_r, dps_pkg::RESP_SLVERR, "unmapped write");
    cmp[2] <= 1'b1;
    exp_evt = 32'h8;
    tick(3);
    ev();
    chk(uv_thresh_sel, 1, "threshold moved");
    rd(dps_pkg::STATUS_OFF);
    chk(rd_v[0], 1, "adaptor status");
    wr(dps_pkg::MASK_OFF, 32'h0);
    chk(interrupt_out_n, 0, "irq on event");
    clr();
    tick(2);
    chk(interrupt_out_n, 1, "irq released");
    for (int f = 0; f < 4; f++) begin
      wr(dps_pkg::CTRL_OFF, 32'h09 | (f << 1));
      tick(4);
      chk(switch_freq, f, "frequency");
      chk({reverse_block, doubler_run}, 2'b01, "running");
    end
    for (int i = 0; i < 7; i++) begin
      run();
      cmp[src[i]] <= 1'b1;
      tick(lim[i] - 1);
      cmp[src[i]] <= 1'b0;
      tick(3);
      ev();
      cmp[src[i]] <= 1'b1;
      tick(lim[i] + 2);
      chk(out_pulldown, i == 2, "out pull-down");
      cmp[src[i]] <= 1'b0;
      exp_evt = 32'h1 << eb[i];
      tick(3);
      chk(doubler_run, 0, "trip");
      chk(reverse_block, 1, "blocked");
      chk(interrupt_out_n, 0, "irq");
      wr(dps_pkg::CTRL_OFF, 32'h09);
      ev();
      rd(dps_pkg::CTRL_OFF);
      chk(rd_v[0], 0, "enable refused");
      clr();
    end
    for (int i = 4; i < 6; i++) begin
      wr(dps_pkg::CTRL_OFF, 32'h08);
      cmp[src[i]] <= 1'b1;
      run();
      exp_evt = 32'h1 << eb[i];
      ev();
      chk(doubler_run, 0, "start aborted");
      cmp[src[i]] <= 1'b0;
      clr();
      run();
      chk(doubler_run, 1, "resumed");
    end
    wr(dps_pkg::CTRL_OFF, 32'h08);
    enable_pin_n <= 1'b0;
    tick(5);
    chk(doubler_run, 1, "pin start");
    enable_pin_n <= 1'b1;
    tick(5);
    chk(doubler_run, 0, "pin stop");
    lvl = xs();
    lvl = {8'h0, 8'h50, 1'b0, lvl[14:8] | 7'h1, 1'b0, lvl[6:0] | 7'h1};
    wr(dps_pkg::LEVEL_OFF, lvl);
    wr(dps_pkg::CTRL_OFF, 32'h01);
    adc(dps_pkg::CH_VBAT, 8'hff);
    adc(dps_pkg::CH_IIN, 8'hff);
    ev();
    wr(dps_pkg::CTRL_OFF, 32'h19);
    tick(4);
    adc(dps_pkg::CH_VBAT, lvl[7:0]);
    adc(dps_pkg::CH_IIN, lvl[15:8]);
    ev();
    adc(dps_pkg::CH_VBAT, lvl[7:0] + 8'h1);
    exp_evt = 32'h100;
    ev();
    adc(dps_pkg::CH_IIN, lvl[15:8] + 8'h1);
    exp_evt = 32'h300;
    ev();
    chk(doubler_run, 0, "overcurrent stop");
    clr();
    adc(dps_pkg::CH_TJUNC, 8'h51);
    exp_evt = 32'h400;
    ev();
    rd(dps_pkg::STATUS_OFF);
    chk(rd_v[2], 1, "warn status high");
    clr();
    adc(dps_pkg::CH_TJUNC, 8'h4f);
    exp_evt = 32'h400;
    ev();
    rd(dps_pkg::STATUS_OFF);
    chk(rd_v[2], 0, "warn status low");
    clr();
    run();
    cmp[9] <= 1'b1;
    tick(4);
    exp_evt = 32'h800;
    ev();
    chk(doubler_run, 0, "critical idle");
    cmp[10] <= 1'b1;
    tick(4);
    cmp[10] <= 1'b0;
    tick(4);
    rd(dps_pkg::STATUS_OFF);
    chk(rd_v[5:4], 2, "shutdown held");
    wr(dps_pkg::MASK_OFF, 32'hfff);
    tick(2);
    chk(interrupt_out_n, 1, "irq masked");
    cmp[9] <= 1'b0;
    tick(6);
    chk(doubler_run, 1, "resume after cool");
    cmp[3] <= 1'b1;
    exp_evt = 32'h820;
    tick(4);
    chk(in_pulldown, 1, "input pull-down");
    ev();
    cmp[2] <= 1'b0;
    tick(4);
    chk(doubler_run, 0, "adaptor removed");
    rd(dps_pkg::STATUS_OFF);
    chk(rd_v[0], 0, "adaptor status cleared");
    rd(dps_pkg::CTRL_OFF);
    chk(rd_v[0], 0, "enable cleared on removal");
    tally_and_finish();
  end
endmodule
